// file: ppic_counter.v
`default_nettype none
`include "ppic_defines.vh"
// ************************************************************
// Operation
// ************************************************************
module ppic_counter #(
   parameter CNT_W      = `PPIC_CNT_W,
   parameter TICK_CYC   = `PPIC_TICK_CYCLES,
   parameter DEPTH      = `PPIC_RESULT_DEPTH,
   parameter AW         = `PPIC_RESULT_AW
) (
   input  wire             clk,
   input  wire             rst,
   input  wire [1:0]       sig_pulse,
   input  wire [1:0]       ref_pulse,
   input  wire             encoder_pulse,
   input  wire             trig_source,
   input  wire             run,
   input  wire [15:0]      interval_ms,
   input  wire             overrange_in,
   input  wire             fwd_req,
   input  wire             bwd_req,
   input  wire             fwd_pin_in,
   input  wire             bwd_pin_in,
   input  wire             res_wr,
   input  wire [AW-1:0]    res_waddr,
   input  wire [CNT_W-1:0] res_wdata,
   input  wire [AW-1:0]    res_raddr,
   output reg  [CNT_W-1:0] res_rdata,
   output reg  [CNT_W-1:0] idle_sig0,
   output reg  [CNT_W-1:0] idle_ref0,
   output reg  [CNT_W-1:0] idle_sig1,
   output reg  [CNT_W-1:0] idle_ref1,
   output reg              swap_pulse,
   output reg              active_bank,
   output reg              overrange,
   output reg              motor_forward_cmd,
   output reg              motor_backward_cmd,
   output reg              motor_forward_oe_n,
   output reg              motor_backward_oe_n,
   output reg              int_motor_fwd,
   output reg              int_motor_bwd
);
   wire [1:0] sig_r;
   wire [1:0] ref_r;
   wire       enc_r;
   wire       or_lvl;
   wire       fwd_lvl;
   wire       bwd_lvl;
   reg  [31:0]       tick_cnt;
   reg  [15:0]       ms_cnt;
   reg  [CNT_W-1:0]  act_sig [0:1];
   reg  [CNT_W-1:0]  act_ref [0:1];
   reg  [CNT_W-1:0]  res_mem [0:DEPTH-1];
   reg               trig;
   integer           ch;
   reg  [2:0]        fwd_rel_cnt;
   reg  [2:0]        bwd_rel_cnt;
   wire              fwd_sense_ok;
   wire              bwd_sense_ok;

   // one-bit pulse added to a count, wraps at full scale
   function [CNT_W-1:0] add_pulse;
      input [CNT_W-1:0] cnt;
      input             pulse;
      begin
         add_pulse = cnt + {{(CNT_W-1){1'b0}}, pulse};
      end
   endfunction

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : chan
         ppic_edge_sync u_sig (.clk(clk), .rst(rst), .pin(sig_pulse[g]),
                               .level(), .rise(sig_r[g]));
         ppic_edge_sync u_ref (.clk(clk), .rst(rst), .pin(ref_pulse[g]),
                               .level(), .rise(ref_r[g]));
      end
   endgenerate
   ppic_edge_sync u_enc (.clk(clk), .rst(rst), .pin(encoder_pulse), .level(), .rise(enc_r));
   ppic_edge_sync u_or  (.clk(clk), .rst(rst), .pin(overrange_in), .level(or_lvl), .rise());
   ppic_edge_sync u_fw  (.clk(clk), .rst(rst), .pin(fwd_pin_in), .level(fwd_lvl), .rise());
   ppic_edge_sync u_bw  (.clk(clk), .rst(rst), .pin(bwd_pin_in), .level(bwd_lvl), .rise());

   // ************************************************************
   // trigger generation
   // ************************************************************
   // timer or encoder
   always @* begin
      if (trig_source == `PPIC_SRC_ENCODER)
         trig = run && enc_r;
      else
         trig = run && (tick_cnt == TICK_CYC - 1) && (ms_cnt + 16'h0001 >= interval_ms);
   end

   // millisecond tick and interval count
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_cnt <= 32'h00000000;
         ms_cnt   <= 16'h0000;
      end else if (!run || trig_source == `PPIC_SRC_ENCODER) begin
         tick_cnt <= 32'h00000000;
         ms_cnt   <= 16'h0000;
      end else if (tick_cnt == TICK_CYC - 1) begin
         tick_cnt <= 32'h00000000;
         ms_cnt   <= trig ? 16'h0000 : ms_cnt + 16'h0001;
      end else begin
         tick_cnt <= tick_cnt + 32'h00000001;
      end
   end

   // ************************************************************
   // ping-pong counters
   // ************************************************************
   // one trigger for both channels; reference counted unscaled
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         for (ch = 0; ch < 2; ch = ch + 1) begin
            act_sig[ch] <= `PPIC_CNT_RST;
            act_ref[ch] <= `PPIC_CNT_RST;
         end
         idle_sig0   <= `PPIC_CNT_RST;
         idle_ref0   <= `PPIC_CNT_RST;
         idle_sig1   <= `PPIC_CNT_RST;
         idle_ref1   <= `PPIC_CNT_RST;
         active_bank <= 1'b0;
         swap_pulse  <= 1'b0;
      end else begin
         swap_pulse <= trig;
         if (trig) begin
            // hand final counts over at swap
            idle_sig0   <= add_pulse(act_sig[0], sig_r[0]);
            idle_ref0   <= add_pulse(act_ref[0], ref_r[0]);
            idle_sig1   <= add_pulse(act_sig[1], sig_r[1]);
            idle_ref1   <= add_pulse(act_ref[1], ref_r[1]);
            active_bank <= ~active_bank;
            for (ch = 0; ch < 2; ch = ch + 1) begin
               act_sig[ch] <= `PPIC_CNT_RST;
               act_ref[ch] <= `PPIC_CNT_RST;
            end
         end else if (run) begin
            for (ch = 0; ch < 2; ch = ch + 1) begin
               act_sig[ch] <= add_pulse(act_sig[ch], sig_r[ch]);
               act_ref[ch] <= add_pulse(act_ref[ch], ref_r[ch]);
            end
         end
      end
   end
   // idle outputs stay stable until next swap

   // ************************************************************
   // overrange and motor lines
   // ************************************************************
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         overrange           <= 1'b0;
         motor_forward_cmd   <= 1'b1;
         motor_backward_cmd  <= 1'b1;
         motor_forward_oe_n  <= 1'b1;
         motor_backward_oe_n <= 1'b1;
         int_motor_fwd       <= 1'b0;
         int_motor_bwd       <= 1'b0;
      end else begin
         overrange <= or_lvl;
         motor_forward_cmd   <= 1'b0;
         motor_backward_cmd  <= 1'b0;
         motor_forward_oe_n  <= !(fwd_req && !bwd_req);
         motor_backward_oe_n <= !(bwd_req && !fwd_req);
         int_motor_fwd <= (fwd_req && !bwd_req) || (!fwd_lvl && fwd_sense_ok);
         int_motor_bwd <= (bwd_req && !fwd_req) || (!bwd_lvl && bwd_sense_ok);
      end
   end

   // ************************************************************
   // motor line release hold-off
   // ************************************************************
   // ignore own drive until settled
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         fwd_rel_cnt <= 3'h0;
         bwd_rel_cnt <= 3'h0;
      end else begin
         // restart while driving, count to the settle point once released
         if (!motor_forward_oe_n)
            fwd_rel_cnt <= 3'h0;
         else if (!fwd_sense_ok)
            fwd_rel_cnt <= fwd_rel_cnt + 3'h1;
         if (!motor_backward_oe_n)
            bwd_rel_cnt <= 3'h0;
         else if (!bwd_sense_ok)
            bwd_rel_cnt <= bwd_rel_cnt + 3'h1;
      end
   end
   // synchroniser still shows our own low level for a few cycles after release
   assign fwd_sense_ok = (fwd_rel_cnt >= `PPIC_MOTOR_SETTLE);
   assign bwd_sense_ok = (bwd_rel_cnt >= `PPIC_MOTOR_SETTLE);

   // ************************************************************
   // result memory
   // ************************************************************
   // processor-filled result store
   always @(posedge clk) begin
      if (res_wr)
         res_mem[res_waddr] <= res_wdata;
   end
   always @(posedge clk or posedge rst) begin
      if (rst)
         res_rdata <= `PPIC_CNT_RST;
      else
         res_rdata <= res_mem[res_raddr];
   end
endmodule
`default_nettype wire

// file: ppic_defines.vh
`ifndef PPIC_DEFINES_VH
`define PPIC_DEFINES_VH
// ************************************************************
// clock and timing
// ************************************************************
`define PPIC_CLK_MHZ        200
`define PPIC_TICK_US        1000
`define PPIC_TICK_CYCLES    (`PPIC_TICK_US * `PPIC_CLK_MHZ)
`define PPIC_MOTOR_SETTLE   3'h4
// ************************************************************
// widths and reset values
// ************************************************************
`define PPIC_CNT_W          32
`define PPIC_CNT_RST        32'h00000000
`define PPIC_INTERVAL_W     16
`define PPIC_INTERVAL_RST   16'h0001
`define PPIC_RESULT_DEPTH   5200
`define PPIC_RESULT_AW      13
// ************************************************************
// trigger source select
// ************************************************************
`define PPIC_SRC_TIMER      1'b0
`define PPIC_SRC_ENCODER    1'b1
`endif

// file: ppic_edge_sync.v
`default_nettype none
`include "ppic_defines.vh"
// three-stage pin synchroniser; rising edge once stages two and three agree
module ppic_edge_sync (
   input  wire clk,
   input  wire rst,
   input  wire pin,
   output reg  level,
   output wire rise
);
   reg s1;
   reg s2;
   reg s3;
   // ************************************************************
   // synchroniser chain
   // ************************************************************
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         s1    <= 1'b0;
         s2    <= 1'b0;
         s3    <= 1'b0;
         level <= 1'b0;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3)
            level <= s3;   // accepted level
      end
   end
   // one pulse per accepted rising change
   assign rise = (s2 == s3) && s3 && !level;
endmodule
`default_nettype wire

// file: ppic_counter_chk.sv
`default_nettype none
module ppic_counter_chk #(
   parameter CNT_W = 32
) (
   input wire logic             clk,
   input wire logic             rst,
   input wire logic             run,
   input wire logic             overrange_in,
   input wire logic             fwd_req,
   input wire logic             bwd_req,
   input wire logic             fwd_pin_in,
   input wire logic [CNT_W-1:0] idle_sig0,
   input wire logic             swap_pulse,
   input wire logic             active_bank,
   input wire logic             overrange,
   input wire logic             motor_forward_oe_n,
   input wire logic             motor_backward_oe_n,
   input wire logic             int_motor_fwd
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ******************************
   // assertions
   // ******************************
   a_swap_one_cycle: assert property (swap_pulse |=> !swap_pulse)
      else $error("swap pulse too long");
   a_bank_flips: assert property (swap_pulse |-> active_bank != $past(active_bank))
      else $error("bank kept at swap");
   a_idle_holds: assert property (!swap_pulse |-> $stable(idle_sig0))
      else $error("idle count moved");
   a_run_gates: assert property (!run [*6] |=> !swap_pulse)
      else $error("swap while stopped");
   a_over_raise: assert property (overrange_in [*6] |-> overrange)
      else $error("overrange missed");
   a_over_clear: assert property (!overrange_in [*6] |-> !overrange)
      else $error("overrange stuck");
   a_fwd_drive: assert property ((fwd_req && !bwd_req) [*5]
      |-> !motor_forward_oe_n && motor_backward_oe_n)
      else $error("forward line not driven");
   a_manual_fwd: assert property ((!fwd_req && !bwd_req && !fwd_pin_in) [*7]
      |-> int_motor_fwd && motor_forward_oe_n)
      else $error("manual forward ignored");
   // main scenarios reached
   c_swap: cover property (swap_pulse);
   c_over: cover property ($rose(overrange));
   c_manual: cover property ($rose(int_motor_fwd) && motor_forward_oe_n);
endmodule
bind ppic_counter ppic_counter_chk #(.CNT_W(CNT_W)) u_chk (.clk, .rst, .run, .overrange_in,
   .fwd_req, .bwd_req, .fwd_pin_in, .idle_sig0, .swap_pulse, .active_bank, .overrange,
   .motor_forward_oe_n, .motor_backward_oe_n, .int_motor_fwd);
`default_nettype wire

// file: ppic_host_model.sv
`default_nettype none
module ppic_host_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        swap_pulse,
   input  wire logic [31:0] idle_sig0,
   input  wire logic [31:0] idle_ref0,
   output var  logic        res_wr,
   output var  logic [12:0] res_waddr,
   output var  logic [31:0] res_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         res_wr <= 1'b0;
         res_waddr <= 13'h1FFF;
         res_wdata <= 32'h0;
      end else begin
         res_wr <= swap_pulse;
         if (swap_pulse) begin
            res_waddr <= res_waddr + 13'h1;
            res_wdata <= {idle_sig0[29:0], 2'b00} - idle_ref0;
         end
      end
   end
endmodule
`default_nettype wire

// file: ppic_counter_bench.sv
`default_nettype none
module ppic_counter_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TICK = 10;
   logic [1:0] sig_pulse = 2'b00, ref_pulse = 2'b00;
   logic clk = 1'b0, rst = 1'b1, encoder_pulse = 1'b0, trig_source = 1'b1, run = 1'b0;
   logic overrange_in = 1'b0, fwd_req = 1'b0, bwd_req = 1'b0, op_fwd = 1'b0, op_bwd = 1'b0;
   logic [12:0] res_raddr = 13'h0000;
   logic [15:0] interval_ms = 16'h0003;
   logic exp_bank = 1'b0;
   wire logic [31:0] res_rdata, idle_sig0, idle_ref0, idle_sig1, idle_ref1, res_wdata;
   wire logic [12:0] res_waddr;
   wire logic swap_pulse, active_bank, overrange, motor_forward_cmd, motor_backward_cmd;
   wire logic motor_forward_oe_n, motor_backward_oe_n, int_motor_fwd, int_motor_bwd, res_wr;
   wire logic fwd_pin_in, bwd_pin_in;
   int mismatches = 0, cmp_count = 0, cyc = 0, last = 0, gap = 0, seed;
   logic [127:0] exp_q[$];
   logic [31:0] exp_r[$];
   // open-drain lines with pull-up and operator switch
   assign fwd_pin_in = (motor_forward_oe_n ? 1'b1 : motor_forward_cmd) & ~op_fwd;
   assign bwd_pin_in = (motor_backward_oe_n ? 1'b1 : motor_backward_cmd) & ~op_bwd;
   always #2.5 clk = ~clk;
   ppic_counter #(.TICK_CYC(TICK)) uut (.clk, .rst, .sig_pulse, .ref_pulse, .encoder_pulse,
      .trig_source, .run, .interval_ms, .overrange_in, .fwd_req, .bwd_req,
      .fwd_pin_in, .bwd_pin_in, .res_wr, .res_waddr, .res_wdata, .res_raddr, .res_rdata,
      .idle_sig0, .idle_ref0, .idle_sig1, .idle_ref1, .swap_pulse, .active_bank, .overrange,
      .motor_forward_cmd, .motor_backward_cmd, .motor_forward_oe_n, .motor_backward_oe_n,
      .int_motor_fwd, .int_motor_bwd);
   ppic_host_model host (.clk, .rst, .swap_pulse, .idle_sig0, .idle_ref0, .res_wr,
      .res_waddr, .res_wdata);
   task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic stop_test;
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // one period of pulses on all four inputs, then an encoder trigger
   task automatic period(input int n0, input int r0, input int n1, input int r1);
      exp_q.push_back({n0[31:0], r0[31:0], n1[31:0], r1[31:0]});
      exp_r.push_back(32'(4 * n0 - r0));
      for (int i = 0; i < 20; i++) begin
         sig_pulse = {i < n1, i < n0};
         ref_pulse = {i < r1, i < r0};
         repeat (3) @(negedge clk);
         sig_pulse = 2'b00;
         ref_pulse = 2'b00;
         repeat (3) @(negedge clk);
      end
      repeat (6) @(negedge clk);
      encoder_pulse = 1'b1;
      repeat (3) @(negedge clk);
      encoder_pulse = 1'b0;
      repeat (8) @(negedge clk);
   endtask
   // cycle count for period measurement
   always @(posedge clk) cyc <= cyc + 1;
   // compare handed-over counts against oldest note
   always @(negedge clk) begin
      if (swap_pulse === 1'b1) begin
         gap = cyc - last;
         last = cyc;
         exp_bank = ~exp_bank;
         check("active_bank", active_bank, exp_bank);
         if (exp_q.size() == 0)
            check("unexpected_swap", 1, 0);
         else
            check("idle_counts", {idle_sig0, idle_ref0, idle_sig1, idle_ref1},
               exp_q.pop_front());
      end
   end
   // main sequence
   initial begin
      seed = $urandom(45);
      repeat (3) @(negedge clk);
      rst = 1'b0;
      repeat (8) @(negedge clk);
      run = 1'b1;
      repeat (4) period($urandom_range(20), $urandom_range(20), $urandom_range(20), 20);
      foreach (exp_r[k]) begin
         res_raddr = 13'(k);
         @(negedge clk);
         check("result_word", res_rdata, exp_r[k]);
      end
      interval_ms = 16'($urandom_range(3));
      trig_source = 1'b0;
      repeat (3) exp_q.push_back(128'h0);
      repeat (3) @(posedge swap_pulse);
      @(negedge clk);
      run = 1'b0;
      @(negedge clk);
      check("timer_period", gap, (interval_ms == 16'h0000 ? 1 : interval_ms) * TICK);
      overrange_in = 1'b1;
      repeat (8) @(negedge clk);
      check("overrange", overrange, 1);
      overrange_in = 1'b0;
      repeat (8) @(negedge clk);
      check("overrange_clear", overrange, 0);
      for (int m = 0; m < 4; m++) begin
         {fwd_req, bwd_req, op_fwd, op_bwd} = 4'h8 >> m;
         repeat (8) @(negedge clk);
         check("motor", {motor_forward_oe_n, motor_backward_oe_n, int_motor_fwd,
            int_motor_bwd}, 16'h69ED >> (12 - 4 * m) & 16'h000F);
         check("motor_level", {motor_forward_cmd, motor_backward_cmd}, 0);
      end
      repeat (40) @(negedge clk);
      check("notes_left", exp_q.size(), 0);
      stop_test();
   end
   // watchdog
   initial begin
      #10us;
      mismatches++;
      stop_test();
   end
endmodule
`default_nettype wire
